// >>> inc/gpr_pkg.sv
package gpr_pkg;
  localparam int PORT_W = 8;
  // Register byte addresses on the APB bus.
  localparam logic [7:0] OFS_DIRECTION = 8'h00;
  localparam logic [7:0] OFS_LATCH = 8'h04;
  localparam logic [7:0] OFS_PIN_LEVEL = 8'h08;
  localparam logic [7:0] OFS_ANALOG = 8'h0C;
  localparam logic [7:0] OFS_REMAP = 8'h10;
  // Pins 1:0 have no analog function.
  localparam logic [7:0] ANALOG_IMPL_MASK = 8'hFC;
  // Remap fuse word bit positions.
  localparam int BIT_COMPARE2_REMAP = 0;
  localparam int BIT_COMPARE3_REMAP = 2;
  localparam int BIT_TIMER3_REMAP = 4;
  localparam int BIT_PWM2B_REMAP = 5;
  localparam logic [7:0] REMAP_IMPL_MASK = 8'h35;
  // Reset values.
  localparam logic [7:0] RST_DIRECTION = 8'hFF;
  localparam logic [7:0] RST_LATCH = 8'h00;
  localparam logic [7:0] RST_ANALOG = 8'hFC;
  localparam logic [7:0] RST_REMAP = 8'h35;
  // Pins of port C that remapped functions reach.
  localparam int PC_PWM2B = 0;
  localparam int PC_TIMER3_CLK = 0;
  localparam int PC_COMPARE2 = 1;
  localparam int PC_COMPARE3 = 6;
  localparam int SYNC_STAGES = 3;
endpackage

// >>> logic/gpr_sync.sv
`timescale 1ns/1ns
module gpr_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // Raw and filtered levels.
  input wire logic [WIDTH-1:0] raw_in,
  output logic [WIDTH-1:0] level_out
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= raw_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // A change counts only once the last two stages agree.
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          level_out[i] <= 1'b0;
        end else if (s2_reg[i] == s3_reg[i]) begin
          level_out[i] <= s3_reg[i];
        end
      end
    end
  endgenerate
endmodule

// >>> logic/gpr_pin_mux.sv
`timescale 1ns/1ns
module gpr_pin_mux #(
  parameter int WIDTH = 8
) (
  // Serial override, highest priority.
  input wire logic [WIDTH-1:0] ser_ovr_en,
  input wire logic [WIDTH-1:0] ser_ovr_dir_in,
  input wire logic [WIDTH-1:0] ser_out,
  // Routed peripheral outputs, middle priority.
  input wire logic [WIDTH-1:0] per_oe,
  input wire logic [WIDTH-1:0] per_out,
  // Software latch and direction, lowest priority.
  input wire logic [WIDTH-1:0] direction,
  input wire logic [WIDTH-1:0] latch,
  // Resolved drive.
  output logic [WIDTH-1:0] drv_out,
  output logic [WIDTH-1:0] drv_oe
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_pin
      always_comb begin
        if (ser_ovr_en[i]) begin
          drv_oe[i] = ~ser_ovr_dir_in[i];
          drv_out[i] = ser_out[i];
        end else if (per_oe[i] && !direction[i]) begin
          drv_oe[i] = 1'b1;
          drv_out[i] = per_out[i];
        end else begin
          drv_oe[i] = ~direction[i];
          drv_out[i] = latch[i];
        end
      end
    end
  endgenerate
endmodule

// >>> logic/gpr_port_c.sv
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/1ns
module gpr_port_c
  import gpr_pkg::*;
#(
  parameter bit LARGE_PKG = 1'b0
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Port C pins.
  input wire logic [PORT_W-1:0] pin_in,
  output logic [PORT_W-1:0] pin_out,
  output logic [PORT_W-1:0] pin_oe,
  // Serial units.
  input wire logic [PORT_W-1:0] ser_ovr_en,
  input wire logic [PORT_W-1:0] ser_ovr_dir_in,
  input wire logic [PORT_W-1:0] ser_out,
  output logic [PORT_W-1:0] ser_in,
  // Remappable peripheral functions.
  input wire logic pwm2_output_b,
  input wire logic pwm2_output_b_oe,
  input wire logic compare2_out,
  input wire logic compare2_oe,
  input wire logic compare3_out,
  input wire logic compare3_oe,
  input wire logic port_b_bit5_in,
  input wire logic port_b_bit3_in,
  output logic timer3_clock_input,
  output logic compare2_capture_in,
  // Route flags for the neighbouring ports.
  output logic compare2_on_port_b_bit3,
  output logic compare3_on_port_e_bit0,
  output logic pwm2b_on_default_pin,
  output logic compare3_on_default_pin
);
  logic [7:0] direction_reg_c;
  logic [7:0] output_latch_c;
  logic [7:0] analog_select;
  logic [7:0] pin_remap_fuse_word;
  logic [7:0] pin_sync;
  logic [1:0] pb_sync;
  logic [7:0] pin_level_c;
  logic [7:0] per_oe;
  logic [7:0] per_out;
  logic [7:0] drv_out;
  logic [7:0] drv_oe;
  logic [31:0] rdata_next;
  logic addr_ok;
  logic setup;
  logic wr_fire;
  logic pwm2b_remap_bit;
  logic timer3_clock_remap_bit;
  logic compare2_remap_bit;
  logic compare3_remap_bit;

  // The register map and pin routing only serve an eight-pin port.
  generate
    if (PORT_W != 8) begin : g_bad_width
      $error("port width must be 8");
    end
  endgenerate

  gpr_sync #(.WIDTH(PORT_W)) u_pin_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .raw_in(pin_in),
    .level_out(pin_sync)
  );

  gpr_sync #(.WIDTH(2)) u_pb_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .raw_in({port_b_bit5_in, port_b_bit3_in}),
    .level_out(pb_sync)
  );

  // Analog pins have their digital input path cut off.
  assign pin_level_c = pin_sync & ~analog_select;

  // Remap routing follows the fuse bits directly.
  assign pwm2b_remap_bit = pin_remap_fuse_word[BIT_PWM2B_REMAP];
  assign timer3_clock_remap_bit = pin_remap_fuse_word[BIT_TIMER3_REMAP];
  assign compare2_remap_bit = pin_remap_fuse_word[BIT_COMPARE2_REMAP];
  assign compare3_remap_bit = pin_remap_fuse_word[BIT_COMPARE3_REMAP];

  always_comb begin
    per_oe = '0;
    per_out = '0;
    if (!pwm2b_remap_bit) begin
      per_oe[PC_PWM2B] = pwm2_output_b_oe;
      per_out[PC_PWM2B] = pwm2_output_b;
    end
    if (compare2_remap_bit) begin
      per_oe[PC_COMPARE2] = compare2_oe;
      per_out[PC_COMPARE2] = compare2_out;
    end
    if (!compare3_remap_bit && !LARGE_PKG) begin
      per_oe[PC_COMPARE3] = compare3_oe;
      per_out[PC_COMPARE3] = compare3_out;
    end
  end

  gpr_pin_mux #(.WIDTH(PORT_W)) u_pin_mux (
    .ser_ovr_en(ser_ovr_en),
    .ser_ovr_dir_in(ser_ovr_dir_in),
    .ser_out(ser_out),
    .per_oe(per_oe),
    .per_out(per_out),
    .direction(direction_reg_c),
    .latch(output_latch_c),
    .drv_out(drv_out),
    .drv_oe(drv_oe)
  );

  // Drive ignores the analog select; only direction and priority decide.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out <= '0;
      pin_oe <= '0;
    end else begin
      pin_out <= drv_out;
      pin_oe <= drv_oe;
    end
  end

  // Peripheral inputs and route flags.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer3_clock_input <= 1'b0;
      compare2_capture_in <= 1'b0;
      ser_in <= '0;
      compare2_on_port_b_bit3 <= 1'b0;
      compare3_on_port_e_bit0 <= 1'b0;
      pwm2b_on_default_pin <= 1'b1;
      compare3_on_default_pin <= 1'b1;
    end else begin
      timer3_clock_input <= timer3_clock_remap_bit ? pin_level_c[PC_TIMER3_CLK] : pb_sync[1];
      compare2_capture_in <= compare2_remap_bit ? pin_level_c[PC_COMPARE2] : pb_sync[0];
      ser_in <= pin_level_c;
      compare2_on_port_b_bit3 <= ~compare2_remap_bit;
      compare3_on_port_e_bit0 <= ~compare3_remap_bit & LARGE_PKG;
      pwm2b_on_default_pin <= pwm2b_remap_bit;
      compare3_on_default_pin <= compare3_remap_bit;
    end
  end

  // APB decode: zero wait states, answer prepared in the setup cycle.
  assign setup = psel & ~penable;
  assign wr_fire = psel & penable & pready & pwrite & ~pslverr;
  assign addr_ok = (paddr == OFS_DIRECTION) || (paddr == OFS_LATCH) ||
                   (paddr == OFS_PIN_LEVEL) || (paddr == OFS_ANALOG) ||
                   (paddr == OFS_REMAP);

  always_comb begin
    rdata_next = '0;
    case (paddr)
      OFS_DIRECTION: rdata_next[7:0] = direction_reg_c;
      OFS_LATCH: rdata_next[7:0] = output_latch_c;
      OFS_PIN_LEVEL: rdata_next[7:0] = pin_level_c;
      OFS_ANALOG: rdata_next[7:0] = analog_select & ANALOG_IMPL_MASK;
      OFS_REMAP: rdata_next[7:0] = pin_remap_fuse_word & REMAP_IMPL_MASK;
      default: rdata_next = '0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else if (setup) begin
      pready <= 1'b1;
      pslverr <= ~addr_ok;
      prdata <= pwrite ? 32'h0000_0000 : rdata_next;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      direction_reg_c <= RST_DIRECTION;
    end else if (wr_fire && paddr == OFS_DIRECTION) begin
      direction_reg_c <= pwdata[7:0];
    end
  end

  // Writes to the pin-level address land in the latch.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      output_latch_c <= RST_LATCH;
    end else if (wr_fire && (paddr == OFS_LATCH || paddr == OFS_PIN_LEVEL)) begin
      output_latch_c <= pwdata[7:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      analog_select <= RST_ANALOG;
    end else if (wr_fire && paddr == OFS_ANALOG) begin
      analog_select <= pwdata[7:0] & ANALOG_IMPL_MASK;
    end
  end

  // The fuse word is meant to be set once before the port is used.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_remap_fuse_word <= RST_REMAP;
    end else if (wr_fire && paddr == OFS_REMAP) begin
      pin_remap_fuse_word <= pwdata[7:0] & REMAP_IMPL_MASK;
    end
  end
endmodule

// >>> dv/gpr_port_c_asserts.sv
`timescale 1ns/1ns
module gpr_port_c_asserts
  import gpr_pkg::*;
#(
  parameter bit LARGE_PKG = 1'b0
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_n,
  // APB.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and overrides.
  input wire logic [PORT_W-1:0] pin_out,
  input wire logic [PORT_W-1:0] pin_oe,
  input wire logic [PORT_W-1:0] ser_ovr_en,
  input wire logic [PORT_W-1:0] ser_ovr_dir_in,
  input wire logic [PORT_W-1:0] ser_out,
  // Route flags.
  input wire logic compare2_on_port_b_bit3,
  input wire logic compare3_on_port_e_bit0,
  input wire logic pwm2b_on_default_pin,
  input wire logic compare3_on_default_pin
);
  logic mapped;
  assign mapped = paddr inside {OFS_DIRECTION, OFS_LATCH, OFS_PIN_LEVEL, OFS_ANALOG, OFS_REMAP};
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_remap_wr;
    psel && penable && pready && pwrite && paddr == OFS_REMAP;
  endsequence
  a_ready_pulse: assert property (s_setup |=> pready ##1 !pready)
    else $error("ready is not a single cycle");
  a_err_unmapped: assert property (psel && penable && pready |->
    pslverr == !mapped && (mapped || prdata == '0)) else $error("bad error response");
  a_high_zero: assert property (pready |-> prdata[31:8] == '0)
    else $error("upper read bits set");
  a_rst_quiet: assert property ($rose(rst_n) |-> (pin_oe == '0) [*2])
    else $error("driver on after reset");
  a_ser_in: assert property ((pin_oe & $past(ser_ovr_en & ser_ovr_dir_in)) == '0)
    else $error("forced input still driven");
  a_ser_out: assert property (((~pin_oe | (pin_out ^ $past(ser_out)))
    & $past(ser_ovr_en & ~ser_ovr_dir_in)) == '0) else $error("forced output wrong");
  a_p2b_flag: assert property (s_remap_wr |-> ##2
    pwm2b_on_default_pin == $past(pwdata[BIT_PWM2B_REMAP], 2)) else $error("pwm2b route wrong");
  a_cp2_flag: assert property (s_remap_wr |-> ##2
    compare2_on_port_b_bit3 == !$past(pwdata[BIT_COMPARE2_REMAP], 2))
    else $error("cp2 route wrong");
  a_cp3_route: assert property (s_remap_wr |-> ##2
    compare3_on_default_pin == $past(pwdata[BIT_COMPARE3_REMAP], 2) && compare3_on_port_e_bit0
    == (LARGE_PKG && !$past(pwdata[BIT_COMPARE3_REMAP], 2))) else $error("cp3 route wrong");
endmodule
bind gpr_port_c gpr_port_c_asserts #(.LARGE_PKG(LARGE_PKG)) u_chk (.*);

// >>> dv/gpr_pin_model.sv
`timescale 1ns/1ns
module gpr_pin_model
  import gpr_pkg::*;
(
  // Clock.
  input wire logic core_clk,
  // Device drive.
  input wire logic [PORT_W-1:0] pin_out,
  input wire logic [PORT_W-1:0] pin_oe,
  // Outside drive.
  input wire logic [PORT_W-1:0] ext_lvl,
  input wire logic [PORT_W-1:0] ext_drv,
  // Pad level.
  output logic [PORT_W-1:0] pin_in
);
  logic [PORT_W-1:0] flt = '0;
  // A pad that nobody drives floats, shown as a level that flips every cycle.
  always @(posedge core_clk) flt <= ~flt;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ((ext_drv & ext_lvl) | (~ext_drv & flt)));
endmodule

// >>> dv/test_bidir_port_with_pin_remap.sv
`timescale 1ns/1ns
module test_bidir_port_with_pin_remap;
  import gpr_pkg::*;
  logic core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, rsp_err;
  logic [7:0] paddr = 0, ser_ovr_en = 0, ser_ovr_dir_in = 0, ser_out = 0;
  logic [7:0] ext_lvl = 0, ext_drv = 0, pin_in, pin_out, pin_oe, ser_in;
  logic [31:0] pwdata = 0, prdata, rdat;
  logic pwm2_output_b = 0, pwm2_output_b_oe = 0, compare2_out = 0, compare2_oe = 0;
  logic compare3_out = 0, compare3_oe = 0, port_b_bit5_in = 0, port_b_bit3_in = 0;
  logic timer3_clock_input, compare2_capture_in, pwm2b_on_default_pin, compare3_on_default_pin;
  logic compare2_on_port_b_bit3, compare3_on_port_e_bit0;
  int err_count = 0, checked = 0, cyc = 0;
  gpr_port_c #(.LARGE_PKG(1'b0)) uut (.*);
  gpr_pin_model u_pins (.*);
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      finish_test();
    end
  end
  task automatic finish_test;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("mismatch at %0t: got %h exp %h", $time, s, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdat = prdata;
    rsp_err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  task automatic t_reset;
    rd(OFS_DIRECTION, 32'(RST_DIRECTION));
    rd(OFS_ANALOG, 32'(RST_ANALOG));
    rd(OFS_LATCH, 32'h0);
    rd(OFS_REMAP, 32'(RST_REMAP));
    chk(32'(pin_oe), 32'h0);
    rd(8'h14, 32'h0);
    chk(32'(rsp_err), 32'h1);
  endtask
  task automatic t_drive;
    ext_drv <= 8'h0F;
    ext_lvl <= 8'h06;
    wr(OFS_LATCH, 32'h0000_00A5);
    wr(OFS_ANALOG, 32'h0000_00FF);
    wr(OFS_DIRECTION, 32'h0000_000F);
    tick(6);
    chk(32'(pin_oe), 32'h0000_00F0);
    chk(32'(pin_out & pin_oe), 32'h0000_00A0);
    rd(OFS_ANALOG, 32'h0000_00FC);
    rd(OFS_PIN_LEVEL, 32'h0000_0002);
    rd(OFS_LATCH, 32'h0000_00A5);
    wr(OFS_ANALOG, 32'h0);
    tick(6);
    rd(OFS_PIN_LEVEL, 32'h0000_00A6);
    chk(32'(ser_in), 32'h0000_00A6);
  endtask
  task automatic t_override;
    ser_ovr_en <= 8'h11;
    ser_ovr_dir_in <= 8'h10;
    ser_out <= 8'h01;
    tick(2);
    chk(32'(pin_oe), 32'h0000_00E1);
    chk(32'(pin_out & pin_oe), 32'h0000_00A1);
    rd(OFS_DIRECTION, 32'h0000_000F);
    ser_ovr_en <= 8'h00;
  endtask
  task automatic t_remap;
    logic [7:0] v;
    logic [7:0] tbl [4] = '{8'hFF, 8'h00, 8'h21, 8'h14};
    ext_drv <= 8'hFF;
    ext_lvl <= 8'h01;
    port_b_bit5_in <= 0;
    port_b_bit3_in <= 1;
    wr(OFS_DIRECTION, 32'h0000_00FF);
    for (int i = 0; i < 4; i++) begin
      v = tbl[i] & REMAP_IMPL_MASK;
      wr(OFS_REMAP, 32'(tbl[i]));
      tick(6);
      rd(OFS_REMAP, 32'(v));
      chk(32'(pwm2b_on_default_pin), 32'(v[BIT_PWM2B_REMAP]));
      chk(32'(compare3_on_default_pin), 32'(v[BIT_COMPARE3_REMAP]));
      chk(32'(compare3_on_port_e_bit0), 32'h0);
      chk(32'(compare2_on_port_b_bit3), 32'(!v[BIT_COMPARE2_REMAP]));
      chk(32'(timer3_clock_input), 32'(v[BIT_TIMER3_REMAP]));
      chk(32'(compare2_capture_in), 32'(!v[BIT_COMPARE2_REMAP]));
    end
  endtask
  task automatic t_periph;
    ext_drv <= 8'hBC;
    pwm2_output_b <= 1;
    pwm2_output_b_oe <= 1;
    compare2_out <= 1;
    compare2_oe <= 1;
    compare3_out <= 1;
    compare3_oe <= 1;
    wr(OFS_REMAP, 32'h0);
    wr(OFS_LATCH, 32'h0);
    wr(OFS_ANALOG, 32'h0000_00FC);
    wr(OFS_DIRECTION, 32'h0000_00BC);
    tick(2);
    chk(32'(pin_out & 8'h43), 32'h0000_0041);
  endtask
  initial begin
    tick(4);
    rst_n <= 1;
    tick(1);
    t_reset();
    t_drive();
    t_override();
    t_remap();
    t_periph();
    finish_test();
  end
endmodule
